// ===== dcfsf_pkg.sv
// shared constants for the dual-clock buffer status flag block
package dcfsf_pkg;

    // register port offsets (byte addresses, one aligned word each)
    localparam logic [3:0]  REG_STATUS_OFS     = 4'h0;
    localparam logic [3:0]  REG_NF_OFFSET_OFS  = 4'h4;

    // status word field positions
    localparam int          STAT_FULL_BIT      = 0;
    localparam int          STAT_NEAR_FULL_BIT = 1;
    localparam int          STAT_OVERFLOW_BIT  = 2;
    localparam int          STAT_WPTR_LSB      = 16;

    // configuration defaults and limits
    localparam int          DEFAULT_DATA_WIDTH = 36;
    localparam int          OFFSET_WIDTH       = 12;
    localparam logic [11:0] DEFAULT_NE_OFFSET  = 12'h005;
    localparam logic [11:0] DEFAULT_NF_OFFSET  = 12'h004;
    localparam int          SYNC_STAGES        = 2;

    // flag reset values
    localparam logic        EMPTY_RST          = 1'b1;
    localparam logic        NEAR_EMPTY_RST     = 1'b1;
    localparam logic        FULL_RST           = 1'b0;
    localparam logic        NEAR_FULL_RST      = 1'b0;

    // address bits of the array for a legal data width, zero if illegal
    function automatic int width_to_addr_bits(input int width);
        int bits;
        bits = 0;
        if (width == 4) begin
            bits = 12;
        end else if (width == 9) begin
            bits = 11;
        end else if (width == 18) begin
            bits = 10;
        end else if (width == 36) begin
            bits = 9;
        end
        return bits;
    endfunction : width_to_addr_bits

endpackage : dcfsf_pkg

// ===== dcfsf_gray_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a gray-coded pointer
module dcfsf_gray_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             i_clk,      // destination clock
    input  wire logic             i_resetn,   // async reset, active low
    input  wire logic             i_ce,       // clock enable
    input  wire logic [WIDTH-1:0] i_gray,     // pointer from other domain
    output logic      [WIDTH-1:0] o_gray      // synchronised pointer
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // only one bit moves per step, so a half-caught value is still old or new
    always_comb begin
        meta_d = i_ce ? i_gray : meta_q;
        sync_d = i_ce ? meta_q : sync_q;
    end

    // first stage is read by the second stage alone
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_gray = sync_q;

endmodule : dcfsf_gray_sync

// ===== dcfsf_top.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - empty rises at the read edge that takes the last stored entry.
// - read pointer holds while no valid entries remain.
// - empty falls three read clocks after a write, four in prefetch mode.
// - near-empty is high while stored count is at or below its offset.
// - near-empty falls three clocks after count exceeds the offset.
// - full, near-full and near-empty assert on the same edge that takes the write or read causing them.
// - near flags may fall one cycle late depending on clock phase.
// - read while empty leaves pointer and raises underflow error at once.
// - underflow error clears as soon as read request or empty drops.
// - full rises at the write edge that fills the last free entry.
// - write pointer holds while full so nothing is overwritten.
// - full clears three write clocks after a read on a full buffer.
// - write while full leaves pointer and raises overflow error at once.
// - overflow error clears as soon as write request or full drops.
// - near-full is high while free count is at or below its offset.
// - data width is 4, 9, 18 or 36, default 36; depth follows.
// - prefetch mode shows the first word without a read request.
// - reset forces empty and near-empty high, full and near-full low.
module dcfsf_top #(
    parameter int          DATA_WIDTH           = dcfsf_pkg::DEFAULT_DATA_WIDTH,
    parameter logic [11:0] NEAR_EMPTY_OFFSET    = dcfsf_pkg::DEFAULT_NE_OFFSET,
    parameter logic [11:0] NEAR_FULL_OFFSET     = dcfsf_pkg::DEFAULT_NF_OFFSET,
    parameter bit          PREFETCH_OUTPUT_MODE = 1'b0
) (
    input  wire logic                  i_write_side_clock,   // write domain clock
    input  wire logic                  i_read_side_clock,    // read domain clock
    input  wire logic                  i_resetn,             // async reset, active low
    input  wire logic                  i_ce,                 // clock enable, freezes state
    input  wire logic                  i_write_request,      // write strobe
    input  wire logic [DATA_WIDTH-1:0] i_write_data_in,      // write data
    input  wire logic                  i_read_request,       // read strobe
    output logic      [DATA_WIDTH-1:0] o_read_data,          // output register
    output logic                       o_empty,              // read domain
    output logic                       o_near_empty_flag,    // read domain
    output logic                       o_underflow_error_flag, // read domain
    output logic                       o_full,               // write domain
    output logic                       o_near_full_flag,     // write domain
    output logic                       o_overflow_error_flag,  // write domain
    input  wire logic [3:0]            i_reg_addr,           // register byte address
    input  wire logic [31:0]           i_reg_wdata,          // register write data
    input  wire logic                  i_reg_wr,             // register write strobe
    input  wire logic                  i_reg_rd,             // register read strobe
    output logic      [31:0]           o_reg_rdata           // read data, next cycle
);

    // one extra pointer bit tells a full array from an empty one
    localparam int AW = dcfsf_pkg::width_to_addr_bits(DATA_WIDTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH = PW'(1) << AW;
    localparam logic [PW-1:0] ONE   = PW'(1);

    // refuse widths and offsets the flag logic cannot serve
    if (AW == 0) begin : g_bad_width
        $error("data width must be 4, 9, 18 or 36");
    end
    if ((32'(NEAR_EMPTY_OFFSET) >= (32'(1) << AW)) || (32'(NEAR_FULL_OFFSET) >= (32'(1) << AW))) begin : g_bad_ofs
        $error("near flag offsets must be below the depth");
    end
    // latency figures assume two sync stages; the status word must hold the pointer
    if (dcfsf_pkg::SYNC_STAGES != 2) begin : g_bad_sync
        $error("synchroniser depth is fixed at two stages");
    end
    if (dcfsf_pkg::STAT_WPTR_LSB + PW > 32) begin : g_bad_stat
        $error("write pointer does not fit the status word");
    end

    // msb passes straight, each lower bit folds in the one above it
    function automatic logic [PW-1:0] gray_to_bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        return b;
    endfunction : gray_to_bin

    // storage, written in the write domain only
    logic [DATA_WIDTH-1:0] mem [0:(1<<AW)-1];

    // ---------------- write domain ----------------
    logic [PW-1:0] wbin_q;
    logic [PW-1:0] wbin_d;
    logic [PW-1:0] wgray_q;
    logic [PW-1:0] wgray_d;
    logic          full_q;
    logic          full_d;
    logic          near_full_q;
    logic          near_full_d;
    logic          ovf_q;
    logic          ovf_d;
    logic [11:0]   nf_off_q;
    logic [11:0]   nf_off_d;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    // read pointer gray code, declared here because the write side syncs it
    logic [PW-1:0] rgray_q;
    logic [PW-1:0] rgray_sync;
    logic [PW-1:0] rsync_bin;
    logic [PW-1:0] used_w;
    logic [PW-1:0] free_w;
    logic          wr_take;
    logic [31:0]   status_word;

    // read pointer into the write domain
    dcfsf_gray_sync #(
        .WIDTH (PW)
    ) u_rptr_sync (
        .i_clk    (i_write_side_clock),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .i_gray   (rgray_q),
        .o_gray   (rgray_sync)
    );

    // write pointer, full, near-full and overflow next values
    always_comb begin
        rsync_bin   = gray_to_bin(rgray_sync);
        wr_take     = i_write_request && !full_q;
        wbin_d      = wbin_q + (wr_take ? ONE : '0);
        wgray_d     = wbin_d ^ (wbin_d >> 1);
        used_w      = wbin_d - rsync_bin;
        free_w      = DEPTH - used_w;
        full_d      = (used_w == DEPTH);
        near_full_d = (32'(free_w) <= 32'(nf_off_q));
        ovf_d       = i_write_request && full_q;
        // a low clock enable overrides every next value
        if (!i_ce) begin
            wbin_d      = wbin_q;
            wgray_d     = wgray_q;
            full_d      = full_q;
            near_full_d = near_full_q;
            ovf_d       = ovf_q;
        end
    end

    // flag state, reset to the documented idle levels
    always_ff @(posedge i_write_side_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wbin_q      <= '0;
            wgray_q     <= '0;
            full_q      <= dcfsf_pkg::FULL_RST;
            near_full_q <= dcfsf_pkg::NEAR_FULL_RST;
            ovf_q       <= 1'b0;
        end else begin
            wbin_q      <= wbin_d;
            wgray_q     <= wgray_d;
            full_q      <= full_d;
            near_full_q <= near_full_d;
            ovf_q       <= ovf_d;
        end
    end

    // memory not cleared by reset, so it sits outside the reset process
    always_ff @(posedge i_write_side_clock) begin
        if (i_ce && wr_take) begin
            mem[wbin_q[AW-1:0]] <= i_write_data_in;
        end
    end

    // register port: status read-only, near-full offset writable
    always_comb begin
        status_word = '0;
        status_word[dcfsf_pkg::STAT_FULL_BIT]      = full_q;
        status_word[dcfsf_pkg::STAT_NEAR_FULL_BIT] = near_full_q;
        status_word[dcfsf_pkg::STAT_OVERFLOW_BIT]  = ovf_q;
        status_word[dcfsf_pkg::STAT_WPTR_LSB +: PW] = wbin_q;
        nf_off_d = nf_off_q;
        rdata_d  = '0;
        if (i_reg_wr && (i_reg_addr == dcfsf_pkg::REG_NF_OFFSET_OFS)) begin
            nf_off_d = i_reg_wdata[dcfsf_pkg::OFFSET_WIDTH-1:0];
        end
        if (i_reg_rd) begin
            if (i_reg_addr == dcfsf_pkg::REG_STATUS_OFS) begin
                rdata_d = status_word;
            end else if (i_reg_addr == dcfsf_pkg::REG_NF_OFFSET_OFS) begin
                rdata_d = {20'h00000, nf_off_q};
            end
        end
        if (!i_ce) begin
            nf_off_d = nf_off_q;
            rdata_d  = rdata_q;
        end
    end

    // read data stands for one cycle only, unmapped reads give zero
    always_ff @(posedge i_write_side_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            nf_off_q <= dcfsf_pkg::DEFAULT_NF_OFFSET;
            rdata_q  <= '0;
        end else begin
            nf_off_q <= nf_off_d;
            rdata_q  <= rdata_d;
        end
    end

    // ---------------- read domain ----------------
    logic [PW-1:0]         rbin_q;
    logic [PW-1:0]         rbin_d;
    logic [PW-1:0]         rgray_d;
    logic                  mem_empty_q;
    logic                  mem_empty_d;
    logic                  out_valid_q;
    logic                  out_valid_d;
    logic                  near_empty_q;
    logic                  near_empty_d;
    logic                  unf_q;
    logic                  unf_d;
    logic [DATA_WIDTH-1:0] dout_q;
    logic [DATA_WIDTH-1:0] dout_d;
    logic [PW-1:0]         wgray_sync;
    logic [PW-1:0]         wsync_bin;
    logic [PW-1:0]         count_r;
    logic                  rd_take;
    logic                  pop;
    logic                  empty_shown;

    // write pointer into the read domain; two stages plus flag register give three clocks
    dcfsf_gray_sync #(
        .WIDTH (PW)
    ) u_wptr_sync (
        .i_clk    (i_read_side_clock),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .i_gray   (wgray_q),
        .o_gray   (wgray_sync)
    );

    // prefetch adds the output stage, hence one more clock before empty falls
    always_comb begin
        wsync_bin   = gray_to_bin(wgray_sync);
        empty_shown = PREFETCH_OUTPUT_MODE ? !out_valid_q : mem_empty_q;
        pop         = i_read_request && out_valid_q;
        if (PREFETCH_OUTPUT_MODE) begin
            rd_take = !mem_empty_q && (!out_valid_q || pop);
        end else begin
            rd_take = i_read_request && !mem_empty_q;
        end
        out_valid_d  = rd_take || (out_valid_q && !pop);
        rbin_d       = rbin_q + (rd_take ? ONE : '0);
        rgray_d      = rbin_d ^ (rbin_d >> 1);
        mem_empty_d  = (rbin_d == wsync_bin);
        count_r      = wsync_bin - rbin_d;
        near_empty_d = (32'(count_r) <= 32'(NEAR_EMPTY_OFFSET));
        unf_d        = i_read_request && empty_shown;
        dout_d       = rd_take ? mem[rbin_q[AW-1:0]] : dout_q;
        // a low clock enable overrides every next value
        if (!i_ce) begin
            out_valid_d  = out_valid_q;
            rbin_d       = rbin_q;
            rgray_d      = rgray_q;
            mem_empty_d  = mem_empty_q;
            near_empty_d = near_empty_q;
            unf_d        = unf_q;
            dout_d       = dout_q;
        end
    end

    // read flags and pointer
    always_ff @(posedge i_read_side_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rbin_q       <= '0;
            rgray_q      <= '0;
            mem_empty_q  <= dcfsf_pkg::EMPTY_RST;
            near_empty_q <= dcfsf_pkg::NEAR_EMPTY_RST;
            out_valid_q  <= 1'b0;
            unf_q        <= 1'b0;
        end else begin
            rbin_q       <= rbin_d;
            rgray_q      <= rgray_d;
            mem_empty_q  <= mem_empty_d;
            near_empty_q <= near_empty_d;
            out_valid_q  <= out_valid_d;
            unf_q        <= unf_d;
        end
    end

    // output register keeps its contents through reset
    always_ff @(posedge i_read_side_clock) begin
        dout_q <= dout_d;
    end

    // flag outputs, all straight from flip-flops
    assign o_read_data            = dout_q;
    assign o_empty                = PREFETCH_OUTPUT_MODE ? !out_valid_q : mem_empty_q;
    assign o_near_empty_flag      = near_empty_q;
    assign o_underflow_error_flag = unf_q;
    assign o_full                 = full_q;
    assign o_near_full_flag       = near_full_q;
    assign o_overflow_error_flag  = ovf_q;
    assign o_reg_rdata            = rdata_q;

endmodule : dcfsf_top

// ===== dcfsf_top_props.sv
`timescale 1ns/1ps
// flag checks, each domain on its own clock, both on the one shared reset
module dcfsf_top_props (
    input wire logic i_write_side_clock,     // write clock
    input wire logic i_read_side_clock,      // read clock
    input wire logic i_resetn,               // reset, active low
    input wire logic i_ce,                   // clock enable
    input wire logic i_write_request,        // write strobe
    input wire logic i_read_request,         // read strobe
    input wire logic o_empty,                // empty flag
    input wire logic o_near_empty_flag,      // near-empty flag
    input wire logic o_underflow_error_flag, // read error
    input wire logic o_full,                 // full flag
    input wire logic o_near_full_flag,       // near-full flag
    input wire logic o_overflow_error_flag   // write error
);
    // read side: error tracks attempts on an empty buffer at once
    a_underflow_raise: assert property (@(posedge i_read_side_clock) disable iff (!i_resetn)
        i_ce && i_read_request && o_empty |=> o_underflow_error_flag) else $error("underflow flag missing");
    a_underflow_drop: assert property (@(posedge i_read_side_clock) disable iff (!i_resetn)
        i_ce && (!i_read_request || !o_empty) |=> !o_underflow_error_flag) else $error("underflow flag stuck");
    a_empty_near: assert property (@(posedge i_read_side_clock) disable iff (!i_resetn)
        o_empty |-> o_near_empty_flag) else $error("empty without near-empty");
    // a write just before the rise is seen two edges late at the earliest
    a_empty_hold: assert property (@(posedge i_read_side_clock) disable iff (!i_resetn)
        $rose(o_empty) |-> o_empty[*2]) else $error("empty fell too soon");
    // write side mirrors the read side
    a_overflow_raise: assert property (@(posedge i_write_side_clock) disable iff (!i_resetn)
        i_ce && i_write_request && o_full |=> o_overflow_error_flag) else $error("overflow flag missing");
    a_overflow_drop: assert property (@(posedge i_write_side_clock) disable iff (!i_resetn)
        i_ce && (!i_write_request || !o_full) |=> !o_overflow_error_flag) else $error("overflow flag stuck");
    a_full_near: assert property (@(posedge i_write_side_clock) disable iff (!i_resetn)
        o_full |-> o_near_full_flag) else $error("full without near-full");
    a_full_cause: assert property (@(posedge i_write_side_clock) disable iff (!i_resetn)
        $rose(o_full) |-> $past(i_write_request)) else $error("full rose without a write");
    a_full_hold: assert property (@(posedge i_write_side_clock) disable iff (!i_resetn)
        $rose(o_full) |-> o_full[*2]) else $error("full fell too soon");
    // main scenarios reached
    c_full: cover property (@(posedge i_write_side_clock) $rose(o_full));
    c_overflow: cover property (@(posedge i_write_side_clock) $rose(o_overflow_error_flag));
    c_underflow: cover property (@(posedge i_read_side_clock) $rose(o_underflow_error_flag));
endmodule : dcfsf_top_props

// ===== dcfsf_user.sv
`timescale 1ns/1ps
// writer and reader on their own clocks, driven by task calls
module dcfsf_user (
    input  wire logic   i_wclk,  // write clock
    input  wire logic   i_rclk,  // read clock
    output logic        o_wreq,  // write request
    output logic [35:0] o_wdata, // write word
    output logic        o_rreq   // read request
);
    // requests low through reset; called at time zero so one process drives all
    task automatic idle();
        o_wreq <= 1'b0;
        o_rreq <= 1'b0;
        o_wdata <= 36'h0_0000_0000;
    endtask : idle
    // one word a call; data inverted after so a stale word never passes
    task automatic push(input logic [35:0] d);
        @(posedge i_wclk);
        o_wreq <= 1'b1;
        o_wdata <= d;
        @(posedge i_wclk);
        o_wreq <= 1'b0;
        o_wdata <= ~d;
    endtask : push
    // one strobe; the caller decides whether empty is honoured
    task automatic pop();
        @(posedge i_rclk);
        o_rreq <= 1'b1;
        @(posedge i_rclk);
        o_rreq <= 1'b0;
    endtask : pop
endmodule : dcfsf_user

// ===== dcfsf_top_tb.sv
`timescale 1ns/1ps
module dcfsf_top_tb;
    logic        wclk = 1'b0;
    logic        rclk = 1'b0;
    logic        resetn, ce, wreq, rreq, rwr, rrd;
    logic        empty, nempty, udf, full, nfull, ovf;
    logic [35:0] wdata;
    logic [35:0] rdata;
    logic        pf_empty;
    logic [35:0] pf_rdata;
    logic [3:0]  raddr;
    logic [31:0] rwdata;
    logic [31:0] rrdata;
    logic [31:0] word;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n;
    int          k;
    // read clock period 72 ns, never shares a rising edge with the write clock
    always #25 wclk = ~wclk;
    always #36 rclk = ~rclk;
    dcfsf_top dcfsf_top_i (.i_write_side_clock(wclk), .i_read_side_clock(rclk), .i_resetn(resetn), .i_ce(ce),
        .i_write_request(wreq), .i_write_data_in(wdata), .i_read_request(rreq), .o_read_data(rdata),
        .o_empty(empty), .o_near_empty_flag(nempty), .o_underflow_error_flag(udf), .o_full(full),
        .o_near_full_flag(nfull), .o_overflow_error_flag(ovf), .i_reg_addr(raddr), .i_reg_wdata(rwdata),
        .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rrdata));
    dcfsf_user dcfsf_user_i (.i_wclk(wclk), .i_rclk(rclk), .o_wreq(wreq), .o_wdata(wdata), .o_rreq(rreq));
    // second buffer in prefetch mode on the same inputs; near-empty offset meets the prefetch range
    dcfsf_top #(.PREFETCH_OUTPUT_MODE(1'b1), .NEAR_EMPTY_OFFSET(12'h006)) dcfsf_top_pf_i (
        .i_write_side_clock(wclk), .i_read_side_clock(rclk), .i_resetn(resetn), .i_ce(ce),
        .i_write_request(wreq), .i_write_data_in(wdata), .i_read_request(rreq), .o_read_data(pf_rdata),
        .o_empty(pf_empty), .o_near_empty_flag(), .o_underflow_error_flag(), .o_full(), .o_near_full_flag(),
        .o_overflow_error_flag(), .i_reg_addr(raddr), .i_reg_wdata(rwdata), .i_reg_wr(rwr), .i_reg_rd(rrd),
        .o_reg_rdata());
    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic chk1(input string what, input logic exp, input logic got);
        check(what, {35'h0, exp}, {35'h0, got});
    endtask : chk1
    // register port on the write clock, data one cycle after the strobe
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge wclk);
        raddr <= a;
        rwdata <= d;
        rwr <= 1'b1;
        @(posedge wclk);
        rwr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge wclk);
        raddr <= a;
        rrd <= 1'b1;
        @(posedge wclk);
        rrd <= 1'b0;
        #1 d = rrdata;
    endtask : reg_read
    task automatic complete_run();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // hang guard: the run needs about 2600 write clocks
    always @(posedge wclk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        raddr = 4'h0;
        rwdata = 32'h0000_0000;
        rwr = 1'b0;
        rrd = 1'b0;
        dcfsf_user_i.idle();
        repeat (20) @(posedge wclk);
        resetn <= 1'b1;
        #1;
        chk1("empty", 1'b1, empty);
        chk1("near empty", 1'b1, nempty);
        chk1("full", 1'b0, full);
        chk1("near full", 1'b0, nfull);
        // registers: offset reset value, read-write offset, unmapped address
        reg_read(dcfsf_pkg::REG_NF_OFFSET_OFS, word);
        check("offset reg", 36'h0_0000_0004, 36'(word));
        reg_write(dcfsf_pkg::REG_NF_OFFSET_OFS, 32'h0000_0008);
        reg_read(dcfsf_pkg::REG_NF_OFFSET_OFS, word);
        check("offset reg", 36'h0_0000_0008, 36'(word));
        reg_read(4'h8, word);
        check("unmapped reg", 36'h0_0000_0000, 36'(word));
        // read on an empty buffer
        dcfsf_user_i.pop();
        #1 chk1("underflow", 1'b1, udf);
        @(posedge rclk);
        #1 chk1("underflow", 1'b0, udf);
        // one word, then count read edges until empty falls
        dcfsf_user_i.push(36'h9_1234_5678);
        n = 0;
        do begin
            @(posedge rclk);
            n++;
            #1;
        end while (empty === 1'b1 && n < 8);
        check("empty fall edges", 36'h0_0000_0003, 36'(n));
        chk1("prefetch empty", 1'b1, pf_empty);
        @(posedge rclk);
        #1 chk1("prefetch empty", 1'b0, pf_empty);
        check("prefetch word", 36'h9_1234_5678, pf_rdata);
        dcfsf_user_i.pop();
        #1 check("read word", 36'h9_1234_5678, rdata);
        chk1("empty", 1'b1, empty);
        // clock enable low: the write is dropped and empty stays up
        @(posedge wclk) ce <= 1'b0;
        dcfsf_user_i.push(36'h5_5555_5555);
        repeat (4) @(posedge rclk);
        #1 chk1("frozen empty", 1'b1, empty);
        @(posedge wclk) ce <= 1'b1;
        // fill to the brim, near-full at 8 free slots
        for (k = 0; k < 512; k++) begin
            dcfsf_user_i.push(36'hC_0000_0000 + 36'(k));
            #1;
            if (k == 502) chk1("near full", 1'b0, nfull);
            if (k == 503) chk1("near full", 1'b1, nfull);
            if (k == 510) chk1("full", 1'b0, full);
        end
        chk1("full", 1'b1, full);
        dcfsf_user_i.push(36'h0_0000_0000);
        #1 chk1("overflow", 1'b1, ovf);
        dcfsf_user_i.push(36'h0_0000_0000);
        #1 chk1("overflow", 1'b1, ovf);
        @(posedge wclk);
        #1 chk1("overflow", 1'b0, ovf);
        reg_read(dcfsf_pkg::REG_STATUS_OFS, word);
        check("status", 36'h0_0201_0003, 36'(word));
        // one read frees a slot; full falls three write edges later
        dcfsf_user_i.pop();
        n = 0;
        do begin
            @(posedge wclk);
            n++;
            #1;
        end while (full === 1'b1 && n < 8);
        // count from the read edge itself; full has no phase slack
        check("full clear edges", 36'h0_0000_0003, 36'(n));
        check("read word", 36'hC_0000_0000, rdata);
        // drain past near-empty down to empty
        for (k = 1; k < 512; k++) begin
            dcfsf_user_i.pop();
            #1 check("read word", 36'hC_0000_0000 + 36'(k), rdata);
            if (k == 505) chk1("near empty", 1'b0, nempty);
            if (k == 507) chk1("near empty", 1'b1, nempty);
        end
        chk1("empty", 1'b1, empty);
        chk1("near full", 1'b0, nfull);
        dcfsf_user_i.pop();
        #1 check("read word", 36'hC_0000_01FF, rdata);
        chk1("underflow", 1'b1, udf);
        complete_run();
    end
endmodule : dcfsf_top_tb
bind dcfsf_top dcfsf_top_props dcfsf_top_props_i (.i_write_side_clock(i_write_side_clock),
    .i_read_side_clock(i_read_side_clock), .i_resetn(i_resetn), .i_ce(i_ce), .i_write_request(i_write_request),
    .i_read_request(i_read_request), .o_empty(o_empty), .o_near_empty_flag(o_near_empty_flag),
    .o_underflow_error_flag(o_underflow_error_flag), .o_full(o_full), .o_near_full_flag(o_near_full_flag),
    .o_overflow_error_flag(o_overflow_error_flag));
